// file: core/port_pin_function_select.sv
// pin function select and general port logic for four small ports
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module port_pin_function_select
	import port_mux_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic SRST,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// serial/key pins
	input wire logic [1:0] SK_PIN_IN,
	output logic [1:0] SK_PIN_OUT,
	output logic [1:0] SK_PIN_OE_N,
	output logic [1:0] SK_PULLUP_EN,
	// serial/key peripheral side: index 0 = pin a, 1 = pin b
	input wire logic [1:0] ASYNC_TX_OUT,
	output logic [1:0] KEY_INTR_IN,
	output logic [1:0] ASYNC_RX_IN,
	// six-bit segment port
	input wire logic [5:0] SIX_PIN_IN,
	output logic [5:0] SIX_PIN_OUT,
	output logic [5:0] SIX_PIN_OE_N,
	input wire logic [5:0] LCD_SEG_HIGH,
	// first quad segment port
	input wire logic [3:0] Q1_PIN_IN,
	output logic [3:0] Q1_PIN_OUT,
	output logic [3:0] Q1_PIN_OE_N,
	output logic [3:0] Q1_PULLUP_EN,
	input wire logic [3:0] LCD_SEG_LOW,
	// second quad segment port
	input wire logic [3:0] Q2_PIN_IN,
	output logic [3:0] Q2_PIN_OUT,
	output logic [3:0] Q2_PIN_OE_N,
	output logic [3:0] Q2_PULLUP_EN,
	input wire logic [3:0] LCD_SEG_MID
);
	// all state in one struct
	// one packed struct keeps every flop under one reset and one register process,
	// so no stray flop can miss the synchronous reset
	typedef struct packed {
		logic [1:0] sk_out; // output latch, serial/key
		logic [1:0] sk_dir; // 1 = input
		logic [1:0] sk_pu; // pull-up enable
		logic [5:0] six_out;
		logic [5:0] six_dir;
		logic [3:0] q1_out;
		logic [3:0] q1_dir;
		logic [3:0] q1_pu;
		logic [3:0] q2_out;
		logic [3:0] q2_dir;
		logic [3:0] q2_pu;
		logic [1:0] fsel1; // serial/key alternate select
		logic [5:0] fsel2; // six-bit segment select
		logic [1:0] fsall; // quad segment selects
		logic [1:0] sk_sync; // synchronised pin levels
		logic [5:0] six_sync;
		logic [3:0] q1_sync;
		logic [3:0] q2_sync;
		logic [7:0] rdata;
		logic [1:0] sk_o, sk_oe_n, sk_pue, key_o, rx_o;
		logic [5:0] six_o, six_oe_n;
		logic [3:0] q1_o, q1_oe_n, q1_pue;
		logic [3:0] q2_o, q2_oe_n, q2_pue;
	} state_t;

	state_t st_reg; // registered state
	state_t st_next; // next state
	logic [1:0] sk_alt; // per-pin alternate select, serial/key
	logic [3:0] q1_alt; // per-pin segment select, first quad
	logic [3:0] q2_alt; // per-pin segment select, second quad

	// alternate selects, per single bit
	// the select register keeps pin b in bit 0 and pin a in bit 1, so the pair is swapped here
	assign sk_alt = {st_reg.fsel1[FSEL1_SKB], st_reg.fsel1[FSEL1_SKA]};
	// the quad ports switch as a whole: one global bit fans out to all four pins
	assign q1_alt = {4{st_reg.fsall[FSALL_Q1]}};
	assign q2_alt = {4{st_reg.fsall[FSALL_Q2]}};

	// next-state logic: register writes, readback and pin muxing
	always_comb begin
		st_next = st_reg;
		// register writes
		if (REG_WR) begin
			unique case (REG_ADDR)
				// output latches
				ADDR_OUT_SK: st_next.sk_out = REG_WDATA[SK_HI:SK_LO];
				ADDR_OUT_SIX: st_next.six_out = REG_WDATA[5:0];
				ADDR_OUT_Q1: st_next.q1_out = REG_WDATA[3:0];
				ADDR_OUT_Q2: st_next.q2_out = REG_WDATA[3:0];
				// direction: a one makes the pin an input
				ADDR_DIR_SK: st_next.sk_dir = REG_WDATA[SK_HI:SK_LO];
				ADDR_DIR_SIX: st_next.six_dir = REG_WDATA[5:0];
				ADDR_DIR_Q1: st_next.q1_dir = REG_WDATA[3:0];
				ADDR_DIR_Q2: st_next.q2_dir = REG_WDATA[3:0];
				// pull-up options
				ADDR_PU_SK: st_next.sk_pu = REG_WDATA[SK_HI:SK_LO];
				ADDR_PU_Q1: st_next.q1_pu = REG_WDATA[3:0];
				ADDR_PU_Q2: st_next.q2_pu = REG_WDATA[3:0];
				// function selects take effect on the next edge
				ADDR_FSEL1: st_next.fsel1 = REG_WDATA[1:0];
				ADDR_FSEL2: st_next.fsel2 = REG_WDATA[5:0];
				ADDR_FSALL: st_next.fsall = REG_WDATA[1:0];
				default: ; // unmapped writes are dropped
			endcase
		end
		// read data stands only in the cycle after the strobe
		// a quiet port reads zero, so a late sample never sees stale data
		st_next.rdata = DATA_RST;
		if (REG_RD) begin
			unique case (REG_ADDR)
				// input pins read the synchronised level, outputs the latch
				ADDR_OUT_SK: st_next.rdata = {4'h0,
					(st_reg.sk_dir & st_reg.sk_sync) | (~st_reg.sk_dir & st_reg.sk_out), 2'h0};
				ADDR_OUT_SIX: st_next.rdata = {2'h0,
					(st_reg.six_dir & st_reg.six_sync) | (~st_reg.six_dir & st_reg.six_out)};
				ADDR_OUT_Q1: st_next.rdata = {4'h0,
					(st_reg.q1_dir & st_reg.q1_sync) | (~st_reg.q1_dir & st_reg.q1_out)};
				ADDR_OUT_Q2: st_next.rdata = {4'h0,
					(st_reg.q2_dir & st_reg.q2_sync) | (~st_reg.q2_dir & st_reg.q2_out)};
				// unimplemented direction bits read back as one
				ADDR_DIR_SK: st_next.rdata = DIR_FIX_SK | {4'h0, st_reg.sk_dir, 2'h0};
				ADDR_DIR_SIX: st_next.rdata = DIR_FIX_SIX | {2'h0, st_reg.six_dir};
				ADDR_DIR_Q1: st_next.rdata = DIR_FIX_Q | {4'h0, st_reg.q1_dir};
				ADDR_DIR_Q2: st_next.rdata = DIR_FIX_Q | {4'h0, st_reg.q2_dir};
				// pull-up and select registers read back as written
				ADDR_PU_SK: st_next.rdata = {4'h0, st_reg.sk_pu, 2'h0};
				ADDR_PU_Q1: st_next.rdata = {4'h0, st_reg.q1_pu};
				ADDR_PU_Q2: st_next.rdata = {4'h0, st_reg.q2_pu};
				ADDR_FSEL1: st_next.rdata = {6'h00, st_reg.fsel1};
				ADDR_FSEL2: st_next.rdata = {2'h0, st_reg.fsel2};
				ADDR_FSALL: st_next.rdata = {6'h00, st_reg.fsall};
				default: st_next.rdata = DATA_RST; // unmapped reads as zero
			endcase
		end
		// pin levels are taken as synchronous, one register stage
		// one stage is enough only because the board moves these pins in step with the clock
		st_next.sk_sync = SK_PIN_IN;
		st_next.six_sync = SIX_PIN_IN;
		st_next.q1_sync = Q1_PIN_IN;
		st_next.q2_sync = Q2_PIN_IN;
		// serial/key pins: tx drives an output pin in alternate, rx and key see the pin
		for (int i = 0; i < 2; i++) begin
			st_next.sk_o[i] = sk_alt[i] ? ASYNC_TX_OUT[i] : st_reg.sk_out[i];
			st_next.sk_oe_n[i] = st_reg.sk_dir[i];
			// pull-up only makes sense on an input pin
			st_next.sk_pue[i] = st_reg.sk_pu[i] & st_reg.sk_dir[i];
		end
		// an unrouted key input sits low and an unrouted receive line sits at its idle level,
		// so neither the key logic nor a serial unit sees a false event in port mode
		st_next.key_o = st_reg.sk_sync & sk_alt;
		st_next.rx_o = st_reg.sk_sync | ~sk_alt; // idle high when not routed
		// six-bit port: segment mode forces the driver onto the lcd signal
		// no pull-up exists on this port, so only the driver needs steering
		for (int i = 0; i < 6; i++) begin
			st_next.six_o[i] = st_reg.fsel2[i] ? LCD_SEG_HIGH[i] : st_reg.six_out[i];
			st_next.six_oe_n[i] = st_reg.fsel2[i] ? 1'b0 : st_reg.six_dir[i];
		end
		// quad ports: same scheme plus pull-up killed in segment mode
		// a pull-up fighting a segment driver would skew the lcd levels
		for (int i = 0; i < 4; i++) begin
			st_next.q1_o[i] = q1_alt[i] ? LCD_SEG_LOW[i] : st_reg.q1_out[i];
			st_next.q1_oe_n[i] = q1_alt[i] ? 1'b0 : st_reg.q1_dir[i];
			st_next.q1_pue[i] = ~q1_alt[i] & st_reg.q1_pu[i] & st_reg.q1_dir[i];
			st_next.q2_o[i] = q2_alt[i] ? LCD_SEG_MID[i] : st_reg.q2_out[i];
			st_next.q2_oe_n[i] = q2_alt[i] ? 1'b0 : st_reg.q2_dir[i];
			st_next.q2_pue[i] = ~q2_alt[i] & st_reg.q2_pu[i] & st_reg.q2_dir[i];
		end
	end

	// state register; the active-low board reset is synchronised upstream into SRST
	// zero first, then the fields whose reset level is one
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			st_reg <= '0;
			st_reg.sk_dir <= DIR_RST[SK_HI:SK_LO];
			st_reg.six_dir <= DIR_RST[5:0]; // digital input after reset
			st_reg.q1_dir <= DIR_RST[3:0];
			st_reg.q2_dir <= DIR_RST[3:0];
			// every driver off until software picks a direction or a segment function
			st_reg.sk_oe_n <= '1;
			st_reg.six_oe_n <= '1;
			st_reg.q1_oe_n <= '1;
			st_reg.q2_oe_n <= '1;
			st_reg.rx_o <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flip-flops
	// no logic between flops and pins, so pin timing never depends on the register port
	assign REG_RDATA = st_reg.rdata;
	assign SK_PIN_OUT = st_reg.sk_o;
	assign SK_PIN_OE_N = st_reg.sk_oe_n;
	assign SK_PULLUP_EN = st_reg.sk_pue;
	assign KEY_INTR_IN = st_reg.key_o;
	assign ASYNC_RX_IN = st_reg.rx_o;
	assign SIX_PIN_OUT = st_reg.six_o;
	assign SIX_PIN_OE_N = st_reg.six_oe_n;
	assign Q1_PIN_OUT = st_reg.q1_o;
	assign Q1_PIN_OE_N = st_reg.q1_oe_n;
	assign Q1_PULLUP_EN = st_reg.q1_pue;
	assign Q2_PIN_OUT = st_reg.q2_o;
	assign Q2_PIN_OE_N = st_reg.q2_oe_n;
	assign Q2_PULLUP_EN = st_reg.q2_pue;

	// checks
	// properties run on the core clock; most are switched off while reset is held
	// six-bit and first quad direction registers sit at all-input right after reset
	property p_dir_reset; // direction all input after reset
		@(posedge CORE_CLK) $past(SRST) |-> (st_reg.six_dir == 6'h3f && st_reg.q1_dir == 4'hf);
	endproperty
	a_dir_reset: assert property (p_dir_reset) else $error("direction not input after reset");
	// the six-bit drivers stay off in the cycle after reset ends
	property p_six_input;
		@(posedge CORE_CLK) $past(SRST) |=> (SIX_PIN_OE_N == 6'h3f);
	endproperty
	a_six_input: assert property (p_six_input) else $error("six-bit port not input after reset");
	// a six-bit direction write reaches the enables two edges later while the port is in port mode
	property p_dir_write;
		@(posedge CORE_CLK) disable iff (SRST) (REG_WR && REG_ADDR == ADDR_DIR_SIX && st_reg.fsel2 == 6'h00)
			|=> ##1 (SIX_PIN_OE_N == $past(REG_WDATA[5:0], 2));
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("six-bit direction not applied");
	// segment mode drives every pin of the second quad
	property p_seg_drive;
		@(posedge CORE_CLK) disable iff (SRST) st_reg.fsall[FSALL_Q2] |=> (Q2_PIN_OE_N == 4'h0);
	endproperty
	a_seg_drive: assert property (p_seg_drive) else $error("segment pin not driven");
	// segment mode removes the first quad pull-ups
	property p_seg_pullup;
		@(posedge CORE_CLK) disable iff (SRST) st_reg.fsall[FSALL_Q1] |=> (Q1_PULLUP_EN == 4'h0);
	endproperty
	a_seg_pullup: assert property (p_seg_pullup) else $error("pull-up on in segment mode");
	// a six-bit segment pin carries the lcd signal one edge later
	property p_seg_data;
		@(posedge CORE_CLK) disable iff (SRST) st_reg.fsel2[0] |=> (SIX_PIN_OUT[0] == $past(LCD_SEG_HIGH[0]));
	endproperty
	a_seg_data: assert property (p_seg_data) else $error("segment data not passed");
	// the upper serial/key pin carries the transmit line when routed
	property p_tx_route;
		@(posedge CORE_CLK) disable iff (SRST) sk_alt[1] |=> (SK_PIN_OUT[1] == $past(ASYNC_TX_OUT[1]));
	endproperty
	a_tx_route: assert property (p_tx_route) else $error("serial tx not routed");
	// an enabled pull-up on an input pin reaches the pin
	property p_sk_pullup;
		@(posedge CORE_CLK) disable iff (SRST) (st_reg.sk_pu[0] && st_reg.sk_dir[0]) |=> SK_PULLUP_EN[0];
	endproperty
	a_sk_pullup: assert property (p_sk_pullup) else $error("pull-up not applied");
	// an output pin in port mode drives its latch
	property p_out_mode;
		@(posedge CORE_CLK) disable iff (SRST) (!st_reg.q2_dir[0] && !st_reg.fsall[FSALL_Q2])
			|=> (!Q2_PIN_OE_N[0] && Q2_PIN_OUT[0] == $past(st_reg.q2_out[0]));
	endproperty
	a_out_mode: assert property (p_out_mode) else $error("output mode not driving latch");

	// software writes to the serial/key direction bits show on the enables two edges later
	property p_sk_dir;
		@(posedge CORE_CLK) disable iff (SRST) (REG_WR && REG_ADDR == ADDR_DIR_SK)
			|=> ##1 (SK_PIN_OE_N == $past(REG_WDATA[SK_HI:SK_LO], 2));
	endproperty
	a_sk_dir: assert property (p_sk_dir) else $error("serial/key direction not applied");
	// first quad enables follow a direction write while the port is in port mode
	property p_q1_dir;
		@(posedge CORE_CLK) disable iff (SRST) (REG_WR && REG_ADDR == ADDR_DIR_Q1 && !st_reg.fsall[FSALL_Q1])
			|=> ##1 (Q1_PIN_OE_N == $past(REG_WDATA[3:0], 2));
	endproperty
	a_q1_dir: assert property (p_q1_dir) else $error("first quad direction not applied");
	// second quad enables follow a direction write while the port is in port mode
	property p_q2_dir;
		@(posedge CORE_CLK) disable iff (SRST) (REG_WR && REG_ADDR == ADDR_DIR_Q2 && !st_reg.fsall[FSALL_Q2])
			|=> ##1 (Q2_PIN_OE_N == $past(REG_WDATA[3:0], 2));
	endproperty
	a_q2_dir: assert property (p_q2_dir) else $error("second quad direction not applied");
	// first quad pins carry the lower segment signals in segment mode
	property p_q1_seg;
		@(posedge CORE_CLK) disable iff (SRST) st_reg.fsall[FSALL_Q1] |=> (Q1_PIN_OUT == $past(LCD_SEG_LOW));
	endproperty
	a_q1_seg: assert property (p_q1_seg) else $error("first quad segments not passed");
	// second quad pins carry the middle segment signals in segment mode
	property p_q2_seg;
		@(posedge CORE_CLK) disable iff (SRST) st_reg.fsall[FSALL_Q2] |=> (Q2_PIN_OUT == $past(LCD_SEG_MID));
	endproperty
	a_q2_seg: assert property (p_q2_seg) else $error("second quad segments not passed");
	// an unrouted upper pin leaves its key input low and its receive line idle
	property p_key_idle;
		@(posedge CORE_CLK) disable iff (SRST) !sk_alt[1] |=> (ASYNC_RX_IN[1] && !KEY_INTR_IN[1]);
	endproperty
	a_key_idle: assert property (p_key_idle) else $error("unrouted pin reaches peripheral");
	// a routed lower pin feeds both its key input and its receive line
	property p_rx_route;
		@(posedge CORE_CLK) disable iff (SRST) sk_alt[0]
			|=> (ASYNC_RX_IN[0] == $past(st_reg.sk_sync[0]) && KEY_INTR_IN[0] == $past(st_reg.sk_sync[0]));
	endproperty
	a_rx_route: assert property (p_rx_route) else $error("serial rx or key not routed");
	// the upper pin select bit lands in the alternate select one edge after the write
	property p_fsel1_pin;
		@(posedge CORE_CLK) disable iff (SRST) (REG_WR && REG_ADDR == ADDR_FSEL1)
			|=> (sk_alt[1] == $past(REG_WDATA[FSEL1_SKB]));
	endproperty
	a_fsel1_pin: assert property (p_fsel1_pin) else $error("upper pin select not applied");
	// reset clears every select and pull-up option
	property p_reset_clear;
		@(posedge CORE_CLK) $past(SRST) |-> (st_reg.fsel1 == 2'h0 && st_reg.fsel2 == 6'h00 && st_reg.fsall == 2'h0
			&& st_reg.sk_pu == 2'h0 && st_reg.q1_pu == 4'h0 && st_reg.q2_pu == 4'h0);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("control state not cleared by reset");
	// an enabled first quad pull-up on an input pin in port mode reaches the pin
	property p_q1_pullup;
		@(posedge CORE_CLK) disable iff (SRST) (st_reg.q1_pu[0] && st_reg.q1_dir[0] && !st_reg.fsall[FSALL_Q1])
			|=> Q1_PULLUP_EN[0];
	endproperty
	a_q1_pullup: assert property (p_q1_pullup) else $error("first quad pull-up not applied");
	// a six-bit pin in port mode with direction zero drives its latch
	property p_six_out;
		@(posedge CORE_CLK) disable iff (SRST) (!st_reg.six_dir[0] && !st_reg.fsel2[0])
			|=> (!SIX_PIN_OE_N[0] && SIX_PIN_OUT[0] == $past(st_reg.six_out[0]));
	endproperty
	a_six_out: assert property (p_six_out) else $error("six-bit output mode not driving");
	c_seg_mode: cover property (@(posedge CORE_CLK) st_reg.fsel2 != 6'h00);
	c_tx_mode: cover property (@(posedge CORE_CLK) sk_alt == 2'h3);
	c_out_mode: cover property (@(posedge CORE_CLK) st_reg.q1_dir == 4'h0);
	// main scenarios: a key event routed, a quad port on segments
	c_key_event: cover property (@(posedge CORE_CLK) KEY_INTR_IN[0]);
	c_quad_seg: cover property (@(posedge CORE_CLK) st_reg.fsall != 2'h0);
endmodule : port_pin_function_select
`default_nettype wire

// file: core/port_mux_pkg.sv
// shared constants for the port pin function select block
package port_mux_pkg;
	// register indices on the plain register port (byte addresses as printed)
	localparam logic [7:0] ADDR_OUT_SK = 8'h01; // output latch, serial/key port
	localparam logic [7:0] ADDR_OUT_SIX = 8'h02; // output latch, six-bit port
	localparam logic [7:0] ADDR_OUT_Q1 = 8'h0e; // output latch, first quad port
	localparam logic [7:0] ADDR_OUT_Q2 = 8'h0f; // output latch, second quad port
	localparam logic [7:0] ADDR_DIR_SK = 8'h21; // dir_reg_serial_key_port
	localparam logic [7:0] ADDR_DIR_SIX = 8'h22; // dir_reg_six_bit_port
	localparam logic [7:0] ADDR_DIR_Q1 = 8'h2e; // dir_reg_first_quad_port
	localparam logic [7:0] ADDR_DIR_Q2 = 8'h2f; // dir_reg_second_quad_port
	localparam logic [7:0] ADDR_PU_SK = 8'h31; // pullup_reg_serial_key_port
	localparam logic [7:0] ADDR_PU_Q1 = 8'h3e; // pullup_reg_first_quad_port
	localparam logic [7:0] ADDR_PU_Q2 = 8'h3f; // pullup_reg_second_quad_port
	localparam logic [7:0] ADDR_FSEL1 = 8'h40; // func_select_reg_one
	localparam logic [7:0] ADDR_FSEL2 = 8'h41; // func_select_reg_two
	localparam logic [7:0] ADDR_FSALL = 8'h42; // global_func_select_reg
	// field positions
	localparam int SK_LO = 2; // serial_key_pin_a sits at bit 2
	localparam int SK_HI = 3; // serial_key_pin_b sits at bit 3
	localparam int FSEL1_SKB = 0; // func_select_reg_one: upper pin to alternate
	localparam int FSEL1_SKA = 1; // func_select_reg_one: lower pin to alternate
	localparam int FSALL_Q2 = 0; // global_func_select_reg: second quad to segments
	localparam int FSALL_Q1 = 1; // global_func_select_reg: first quad to segments
	// reset values
	localparam logic [7:0] DIR_RST = 8'hff; // all pins input
	localparam logic [7:0] DATA_RST = 8'h00; // latches, pull-ups, selects
	// fixed-one bits of direction registers (unimplemented pins)
	localparam logic [7:0] DIR_FIX_SK = 8'hf3;
	localparam logic [7:0] DIR_FIX_SIX = 8'hc0;
	localparam logic [7:0] DIR_FIX_Q = 8'hf0;
endpackage : port_mux_pkg

// file: testbench/pin_board_model.sv
// board-side model of the port pins: drivers, external sources, pull-ups
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
	// clock for the floating-line pattern
	input wire logic clk,
	// device side, flattened {q2, q1, six, sk}
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_n,
	input wire logic [15:0] pull_en,
	// board sources
	input wire logic [15:0] ext_en,
	input wire logic [15:0] ext_val,
	// resolved wire levels
	output logic [15:0] pin_lvl
);
	logic flip = 1'b0; // a released line wanders so a stale value never passes
	always @(posedge clk) begin
		flip <= ~flip;
	end
	// device driver first, then the board, then the pull-up
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (!pin_oe_n[i]) begin
				pin_lvl[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_lvl[i] = ext_val[i];
			end else if (pull_en[i]) begin
				pin_lvl[i] = 1'b1;
			end else begin
				pin_lvl[i] = flip ^ i[0];
			end
		end
	end
endmodule : pin_board_model
`default_nettype wire

// file: testbench/port_pin_function_select_test.sv
// self-checking bench for the port pin function select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module port_pin_function_select_test;
	import port_mux_pkg::*;
	logic core_clk = 1'b0; // 250 MHz core clock
	logic srst = 1'b1; // held for the first 20 cycles
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [1:0] sk_out, sk_oe_n, sk_pu, key_in, rx_in;
	logic [1:0] tx_out = 2'b00; // serial transmit lines
	logic [5:0] six_out, six_oe_n;
	logic [5:0] seg_high = 6'h00;
	logic [3:0] q1_out, q1_oe_n, q1_pu, q2_out, q2_oe_n, q2_pu;
	logic [3:0] seg_low = 4'h0;
	logic [3:0] seg_mid = 4'h0;
	logic [15:0] ext_en = 16'h0000; // board drives these pins
	logic [15:0] ext_val = 16'h0000;
	logic [15:0] pin_lvl; // resolved wires {q2, q1, six, sk}
	logic [7:0] dirs [4] = '{ADDR_DIR_SK, ADDR_DIR_SIX, ADDR_DIR_Q1, ADDR_DIR_Q2};
	int n_mismatch = 0;
	int num_checks = 0;
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	pin_board_model board (.clk(core_clk), .pin_out({q2_out, q1_out, six_out, sk_out}),
		.pin_oe_n({q2_oe_n, q1_oe_n, six_oe_n, sk_oe_n}), .pull_en({q2_pu, q1_pu, 6'h00, sk_pu}),
		.ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));
	port_pin_function_select dut (.CORE_CLK(core_clk), .SRST(srst), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.SK_PIN_IN(pin_lvl[1:0]), .SK_PIN_OUT(sk_out), .SK_PIN_OE_N(sk_oe_n), .SK_PULLUP_EN(sk_pu),
		.ASYNC_TX_OUT(tx_out), .KEY_INTR_IN(key_in), .ASYNC_RX_IN(rx_in),
		.SIX_PIN_IN(pin_lvl[7:2]), .SIX_PIN_OUT(six_out), .SIX_PIN_OE_N(six_oe_n), .LCD_SEG_HIGH(seg_high),
		.Q1_PIN_IN(pin_lvl[11:8]), .Q1_PIN_OUT(q1_out), .Q1_PIN_OE_N(q1_oe_n), .Q1_PULLUP_EN(q1_pu),
		.LCD_SEG_LOW(seg_low), .Q2_PIN_IN(pin_lvl[15:12]), .Q2_PIN_OUT(q2_out), .Q2_PIN_OE_N(q2_oe_n),
		.Q2_PULLUP_EN(q2_pu), .LCD_SEG_MID(seg_mid));
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// one-cycle read strobe; data only in the following cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] msk);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata & msk, e, "register read")
	endtask : rd
	// pins follow a write or a pin change two edges later
	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask : settle
	task final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	// watchdog: the sequence needs well under 1000 cycles
	initial begin
		#20000;
		n_mismatch++;
		final_report();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		`CHK({sk_oe_n, six_oe_n, q1_oe_n, q2_oe_n}, 16'hffff, "oe after reset")
		`CHK({sk_pu, q1_pu, q2_pu, rx_in, key_in}, 14'h00c, "idle after reset")
		for (int i = 0; i < 4; i++) rd(dirs[i], 8'hff, 8'hff);
		$display("test reset done");
		@(posedge core_clk);
		ext_en <= 16'h00a8;
		ext_val <= 16'h00b4;
		wr(ADDR_OUT_SIX, 8'h15);
		wr(ADDR_DIR_SIX, 8'h2a);
		settle();
		`CHK(six_oe_n, 6'h2a, "six direction")
		`CHK(six_out & 6'h15, 6'h15, "six latch")
		rd(ADDR_DIR_SIX, 8'hea, 8'hff);
		rd(ADDR_OUT_SIX, 8'h3d, 8'h3f);
		@(posedge core_clk);
		seg_high <= 6'h3a;
		wr(ADDR_FSEL2, 8'h02);
		settle();
		`CHK({six_oe_n, six_out[1]}, 7'h51, "one segment bit")
		wr(ADDR_FSEL2, 8'h3f);
		settle();
		`CHK({six_oe_n, six_out}, 12'h03a, "six segments")
		$display("test six-bit port done");
		wr(ADDR_DIR_Q1, 8'hf5);
		wr(ADDR_PU_Q1, 8'h0f);
		wr(ADDR_PU_Q2, 8'h0a);
		wr(ADDR_DIR_Q2, 8'hf6);
		settle();
		`CHK({q1_oe_n, q1_pu}, 8'h55, "first quad port")
		`CHK({q2_oe_n, q2_pu}, 8'h62, "second quad port")
		rd(ADDR_PU_Q1, 8'h0f, 8'h0f);
		wr(ADDR_OUT_Q1, 8'h02);
		wr(ADDR_OUT_Q2, 8'h09);
		settle();
		`CHK({q1_out, q2_out}, 8'h29, "quad latches")
		rd(ADDR_OUT_Q1, 8'h07, 8'hff);
		rd(ADDR_OUT_Q2, 8'h0b, 8'hfb);
		rd(ADDR_PU_Q2, 8'h0a, 8'hff);
		@(posedge core_clk);
		seg_low <= 4'h9;
		seg_mid <= 4'h6;
		wr(ADDR_FSALL, 8'h02);
		settle();
		`CHK({q1_oe_n, q1_pu, q1_out, q2_oe_n}, 16'h0096, "first quad segments")
		wr(ADDR_FSALL, 8'h01);
		settle();
		`CHK({q2_oe_n, q2_pu, q2_out, q1_oe_n}, 16'h0065, "second quad segments")
		rd(ADDR_FSEL2, 8'h3f, 8'hff);
		rd(ADDR_FSALL, 8'h01, 8'hff);
		$display("test quad ports done");
		wr(ADDR_PU_SK, 8'h0c);
		ext_en <= 16'h0003;
		ext_val <= 16'h0001;
		wr(ADDR_FSEL1, 8'h03);
		settle();
		`CHK({sk_pu, key_in, rx_in}, 6'h35, "both pins alternate")
		wr(ADDR_FSEL1, 8'h02);
		settle();
		`CHK({key_in, rx_in}, 4'h7, "lower pin alternate only")
		@(posedge core_clk);
		ext_en <= 16'h0000;
		tx_out <= 2'b10;
		wr(ADDR_FSEL1, 8'h03);
		wr(ADDR_DIR_SK, 8'hf7);
		settle();
		`CHK({sk_oe_n, sk_out[1], sk_pu[1]}, 4'h6, "transmit on upper pin")
		rd(ADDR_DIR_SK, 8'hf7, 8'hff);
		wr(ADDR_OUT_SK, 8'h04);
		wr(ADDR_FSEL1, 8'h01);
		settle();
		`CHK(sk_out, 2'b11, "upper pin alternate only")
		rd(ADDR_OUT_SK, 8'h04, 8'hff);
		rd(ADDR_FSEL1, 8'h01, 8'hff);
		rd(ADDR_PU_SK, 8'h0c, 8'hff);
		$display("test serial key port done");
		wr(8'h7f, 8'h55);
		rd(8'h7f, 8'h00, 8'hff);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		#1;
		`CHK({sk_oe_n, six_oe_n, q1_oe_n, q2_oe_n, q1_pu}, 20'hffff0, "oe after second reset")
		rd(ADDR_FSALL, 8'h00, 8'hff);
		rd(ADDR_DIR_SIX, 8'hff, 8'hff);
		$display("test reset mid-run done");
		final_report();
	end
endmodule : port_pin_function_select_test
`default_nettype wire
